// File: design/dct_channel.v
// One compare output channel: holds the pin level and passes the enable through as output enable.
// Assumes one-cycle event pulses from the timer core on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defines.vh"
module dct_channel (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Configuration
  input wire en,
  input wire [2:0] cmp_mode,
  input wire updn,
  // Timer events
  input wire match,
  input wire match_down,
  input wire at_zero,
  input wire at_ff,
  // Pin
  output reg pin_out,
  output wire pin_oe
);
  // RULE_12 pin driven in compare mode
  assign pin_oe = en;

  // RULE_15 output only from a flop, never decoded
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_out <= 1'b0;
    else if (en)
    begin
      // RULE_13 RULE_14 action per output mode
      case (cmp_mode)
        `DCT_CMP_SET: if (match) pin_out <= 1'b1;
        `DCT_CMP_CLR: if (match) pin_out <= 1'b0;
        `DCT_CMP_TGL: if (match) pin_out <= ~pin_out;
        `DCT_CMP_UPSET:
        begin
          if (match && !(updn && match_down)) pin_out <= 1'b1;
          else if (updn ? (match && match_down) : at_zero) pin_out <= 1'b0;
        end
        `DCT_CMP_UPCLR:
        begin
          if (match && !(updn && match_down)) pin_out <= 1'b0;
          else if (updn ? (match && match_down) : at_zero) pin_out <= 1'b1;
        end
        `DCT_CMP_SETFF:
        begin
          if (match) pin_out <= 1'b1;
          else if (at_ff) pin_out <= 1'b0;
        end
        `DCT_CMP_CLR00:
        begin
          if (match) pin_out <= 1'b0;
          else if (at_zero) pin_out <= 1'b1;
        end
        default: pin_out <= pin_out;
      endcase
    end
  end
endmodule // dct_channel
`default_nettype wire

// File: design/dct_defines.vh
// Constants for the dual 8-bit compare timer: offsets, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
//
// Behaviour
// RULE_01: 8-bit counter steps once per active edge
// RULE_02: prescaler divides tick by power of two
// RULE_03: prescaler code 000..111 gives /1../128, immediate
// RULE_04: tick rate set by global tick speed
// RULE_05: counter clear bit zeroes the counter
// RULE_06: run bit starts; zero freezes the counter
// RULE_07: mode 00 free, 01 down, 10 modulo, 11 up/down
// RULE_08: free mode wraps at 0xff, overflow at 0xff
// RULE_09: modulo reloads zero at channel 0 value
// RULE_10: down mode loads value, stops at zero
// RULE_11: up/down turns at value, overflow at zero
// RULE_12: compare mode drives pin, compares while running
// RULE_13: equality sets, clears or toggles output
// RULE_14: output mode codes 000..110 as listed
// RULE_15: compare outputs are glitch free
// RULE_16: channel 0 value takes effect at zero
// RULE_17: channel 1 value takes effect at once
// RULE_18: compare match sets channel flag
// RULE_19: up/down channel 0 flag set at zero turn
// RULE_20: up/down channel 1 flag on compare match
// RULE_21: flags set regardless of mask bits
// RULE_22: cpu flag only for unmasked events
// RULE_23: request needs mask and timer enable
// RULE_24: setting mask on pending flag re-requests
// RULE_25: each channel compare gives own dma pulse
// RULE_26: software clears flags by writing zero
// RULE_27: software configures pin and compare enable
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH
// Global register byte offsets
`define DCT_CLKCTL_OFS 12'h000
`define DCT_FLAG_OFS 12'h004
`define DCT_IEN_OFS 12'h008
`define DCT_CPUIF_OFS 12'h00c
// Per-timer register index within its 0x20 window (timer t at 0x20*(t+1))
`define DCT_IDX_CNT 3'h0
`define DCT_IDX_TCTL 3'h1
`define DCT_IDX_CCTL0 3'h2
`define DCT_IDX_CC0 3'h3
`define DCT_IDX_CCTL1 3'h4
`define DCT_IDX_CC1 3'h5
// Timer control fields
`define DCT_DIV_HI 7
`define DCT_DIV_LO 5
`define DCT_RUN 4
`define DCT_OVFM 3
`define DCT_CLR 2
`define DCT_MODE_HI 1
`define DCT_MODE_LO 0
// Channel control fields
`define DCT_CH_IM 6
`define DCT_CMP_HI 5
`define DCT_CMP_LO 3
`define DCT_CH_EN 2
// Reset values
`define DCT_TCTL_RST 8'h08
`define DCT_CCTL_RST 8'h40
`define DCT_CC_RST 8'h00
`define DCT_TSS_RST 3'h0
// Counting modes
`define DCT_MODE_FREE 2'h0
`define DCT_MODE_DOWN 2'h1
`define DCT_MODE_MOD 2'h2
`define DCT_MODE_UPDN 2'h3
// Compare output modes
`define DCT_CMP_SET 3'h0
`define DCT_CMP_CLR 3'h1
`define DCT_CMP_TGL 3'h2
`define DCT_CMP_UPSET 3'h3
`define DCT_CMP_UPCLR 3'h4
`define DCT_CMP_SETFF 3'h5
`define DCT_CMP_CLR00 3'h6
`endif

// File: design/dct_timer.v
// Counter core of one 8-bit timer: prescaler, four modes, events.
// Assumes tick is a one-cycle enable on pclk and clr a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defines.vh"
module dct_timer (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire tick,
  input wire [6:0] div_mask,
  input wire run,
  input wire [1:0] mode,
  input wire clr,
  input wire [7:0] cc0,
  input wire [7:0] cc1,
  // State and one-cycle events
  output reg [7:0] cnt,
  output reg ovf_ev,
  output reg m0_ev,
  output reg m1_ev,
  output reg zero_ev,
  output reg ff_ev,
  output reg down_ev
);
  reg [6:0] pre;
  reg run_d;
  reg down_dir;
  reg [7:0] cc0_act;
  reg [7:0] next_cnt;
  reg next_down;
  reg step_dn;
  reg ovf;
  wire edge_ok;
  // RULE_02 RULE_03 mask applies combinationally, so a change acts at once
  assign edge_ok = run && tick && ((pre & div_mask) == div_mask);

  // Prescaler advances on every tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn) pre <= 7'h00;
    else if (tick) pre <= pre + 7'h01;
  end

  // RULE_16 channel 0 value only adopted while counter sits at zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn) cc0_act <= `DCT_CC_RST;
    else if (cnt == 8'h00) cc0_act <= cc0;
  end

  // RULE_07 next count per mode
  always @*
  begin
    next_cnt = cnt;
    next_down = down_dir;
    step_dn = 1'b0;
    ovf = 1'b0;
    case (mode)
      `DCT_MODE_FREE:
      begin
        // RULE_08 wrap at 0xff, overflow on reaching it
        next_cnt = cnt + 8'h01;
        ovf = (next_cnt == 8'hff);
      end
      `DCT_MODE_MOD:
      begin
        // RULE_09 reload at channel 0 value
        if (cnt == cc0_act) begin next_cnt = 8'h00; ovf = 1'b1; end
        else next_cnt = cnt + 8'h01;
      end
      `DCT_MODE_DOWN:
      begin
        // RULE_10 count to zero and stay
        if (cnt != 8'h00)
        begin
          next_cnt = cnt - 8'h01;
          step_dn = 1'b1;
          ovf = (next_cnt == 8'h00);
        end
      end
      default:
      begin
        // RULE_11 turn at value, overflow at zero
        if (down_dir && cnt != 8'h00)
        begin
          next_cnt = cnt - 8'h01;
          step_dn = 1'b1;
          if (next_cnt == 8'h00) begin next_down = 1'b0; ovf = 1'b1; end
        end
        else if (cnt == cc0_act && cnt != 8'h00)
        begin
          next_cnt = cnt - 8'h01;
          step_dn = 1'b1;
          next_down = 1'b1;
          ovf = (next_cnt == 8'h00);
        end
        else if (cnt != cc0_act) next_cnt = cnt + 8'h01;
      end
    endcase
  end

  // Counter and event pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00; run_d <= 1'b0; down_dir <= 1'b0;
      ovf_ev <= 1'b0; m0_ev <= 1'b0; m1_ev <= 1'b0;
      zero_ev <= 1'b0; ff_ev <= 1'b0; down_ev <= 1'b0;
    end
    else
    begin
      run_d <= run;
      ovf_ev <= 1'b0; m0_ev <= 1'b0; m1_ev <= 1'b0;
      zero_ev <= 1'b0; ff_ev <= 1'b0; down_ev <= 1'b0;
      // RULE_05 clear wins over counting
      if (clr)
      begin
        cnt <= 8'h00;
        down_dir <= 1'b0;
      end
      // RULE_10 start in down mode loads the written value
      else if (run && !run_d && mode == `DCT_MODE_DOWN)
        cnt <= cc0;
      // RULE_01 RULE_06 step only when running and on an active edge
      else if (edge_ok)
      begin
        cnt <= next_cnt;
        down_dir <= next_down;
        ovf_ev <= ovf;
        // RULE_12 RULE_17 compare against live channel 1 value
        m0_ev <= (next_cnt == cc0_act);
        m1_ev <= (next_cnt == cc1);
        zero_ev <= (next_cnt == 8'h00);
        ff_ev <= (next_cnt == 8'hff);
        down_ev <= step_dn;
      end
    end
  end
endmodule // dct_timer
`default_nettype wire

// File: design/dct_top.v
// Top of the dual 8-bit compare timer: APB registers, tick, flags.
// Assumes an APB master on pclk; pins and DMA consumers sit outside.
`timescale 1ns/1ps
`default_nettype none
`include "dct_defines.vh"
module dct_top (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Compare pins, two per timer
  output wire [3:0] cmp_out,
  output wire [3:0] cmp_oe,
  // DMA triggers, one per channel
  output reg [3:0] dma_trig,
  // Interrupt request per timer
  output reg [1:0] irq
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Power-of-two mask: code k gives k low ones
  function [6:0] dct_mask;
    input [2:0] code;
    begin
      dct_mask = 7'h7f >> (3'h7 - code);
    end
  endfunction

  // Address decode: {ok, is_timer, timer, index}
  function [5:0] dct_dec;
    input [11:0] a;
    begin
      dct_dec = 6'h00;
      if (a[1:0] == 2'b00 && a[11:7] == 5'h00)
      begin
        if (a[6:5] == 2'b00)
          dct_dec = {1'b1, 1'b0, 1'b0, a[4:2]} & {3'h7, 3'h3};
        else if (a[6:5] != 2'b11 && a[4:2] <= `DCT_IDX_CC1)
          dct_dec = {1'b1, 1'b1, a[6], a[4:2]};
      end
      // Global window only holds four words
      if (a[1:0] == 2'b00 && a[11:5] == 7'h00 && a[4] == 1'b1)
        dct_dec = 6'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [2:0] tick_speed_select;
  reg [5:0] timer_flag_reg;
  reg [1:0] int_enable_reg;
  reg [1:0] cpu_int_flag_reg;
  reg [7:0] timer_control_reg [0:1];
  reg [7:0] chan_ctl0 [0:1];
  reg [7:0] chan_ctl1 [0:1];
  reg [7:0] channel0_compare_value [0:1];
  reg [7:0] channel1_compare_value [0:1];
  reg [6:0] tick_cnt;
  reg [1:0] pend_d;
  reg [1:0] clr_pulse;
  integer i;

  wire [5:0] dec_a;
  wire acc;
  wire wr;
  wire [2:0] idx;
  wire tsel;
  wire tick;
  wire [15:0] cnt_bus;
  wire [5:0] ev;
  wire [5:0] msk;
  wire [5:0] masked_ev;
  wire [1:0] pend;
  wire [1:0] cpu_set;
  wire [3:0] ch_dma;

  assign dec_a = dct_dec(paddr);
  assign idx = dec_a[2:0];
  assign tsel = dec_a[3];
  // Zero wait states; setup cycle already latched read data
  assign pready = 1'b1;
  assign pslverr = psel && penable && !dec_a[5];
  assign acc = psel && penable && dec_a[5];
  assign wr = acc && pwrite;

  ////////////////////////////////////////////////////////////////////////
  // Global tick

  // RULE_04 tick is pclk divided by 2^tick_speed_select
  assign tick = ((tick_cnt & dct_mask(tick_speed_select))
                 == dct_mask(tick_speed_select));

  // Free-running tick divider
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= 7'h00;
    else
      tick_cnt <= tick_cnt + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration writes

  // Software-written registers; clear bit is a pulse, never stored
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_speed_select <= `DCT_TSS_RST;
      int_enable_reg <= 2'b00;
      clr_pulse <= 2'b00;
      for (i = 0; i < 2; i = i + 1)
      begin
        timer_control_reg[i] <= `DCT_TCTL_RST;
        chan_ctl0[i] <= `DCT_CCTL_RST;
        chan_ctl1[i] <= `DCT_CCTL_RST;
        channel0_compare_value[i] <= `DCT_CC_RST;
        channel1_compare_value[i] <= `DCT_CC_RST;
      end
    end
    else
    begin
      clr_pulse <= 2'b00;
      if (wr && !dec_a[4])
      begin
        if (paddr == `DCT_CLKCTL_OFS)
          tick_speed_select <= pwdata[2:0];
        if (paddr == `DCT_IEN_OFS)
          int_enable_reg <= pwdata[1:0];
      end
      if (wr && dec_a[4])
      begin
        case (idx)
          `DCT_IDX_TCTL:
          begin
            timer_control_reg[tsel] <= pwdata[7:0] & ~(8'h01 << `DCT_CLR);
            // RULE_05 writing one to clear resets counter
            clr_pulse[tsel] <= pwdata[`DCT_CLR];
          end
          `DCT_IDX_CCTL0: chan_ctl0[tsel] <= {1'b0, pwdata[6:2], 2'b00};
          `DCT_IDX_CC0: channel0_compare_value[tsel] <= pwdata[7:0];
          `DCT_IDX_CCTL1: chan_ctl1[tsel] <= {1'b0, pwdata[6:2], 2'b00};
          // RULE_17 unbuffered, timer compares it directly
          `DCT_IDX_CC1: channel1_compare_value[tsel] <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Latched in the setup cycle so prdata comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      prdata <= 32'h00000000;
      if (dec_a[5] && !dec_a[4])
      begin
        case (idx)
          3'h0: prdata <= {29'h0, tick_speed_select};
          3'h1: prdata <= {26'h0, timer_flag_reg};
          3'h2: prdata <= {30'h0, int_enable_reg};
          default: prdata <= {30'h0, cpu_int_flag_reg};
        endcase
      end
      else if (dec_a[5])
      begin
        case (idx)
          `DCT_IDX_CNT: prdata <= {24'h0, cnt_bus[tsel*8 +: 8]};
          `DCT_IDX_TCTL: prdata <= {24'h0, timer_control_reg[tsel]};
          `DCT_IDX_CCTL0: prdata <= {24'h0, chan_ctl0[tsel]};
          `DCT_IDX_CC0: prdata <= {24'h0, channel0_compare_value[tsel]};
          `DCT_IDX_CCTL1: prdata <= {24'h0, chan_ctl1[tsel]};
          default: prdata <= {24'h0, channel1_compare_value[tsel]};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers and channels

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_tmr
      wire ovf_ev;
      wire m0_ev;
      wire m1_ev;
      wire zero_ev;
      wire ff_ev;
      wire down_ev;
      wire [7:0] cnt;
      wire updn;
      wire en0;
      wire en1;
      assign updn = (timer_control_reg[g][`DCT_MODE_HI:`DCT_MODE_LO]
                     == `DCT_MODE_UPDN);
      assign en0 = chan_ctl0[g][`DCT_CH_EN];
      assign en1 = chan_ctl1[g][`DCT_CH_EN];
      assign cnt_bus[g*8 +: 8] = cnt;

      dct_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .div_mask(dct_mask(timer_control_reg[g][`DCT_DIV_HI:`DCT_DIV_LO])),
        .run(timer_control_reg[g][`DCT_RUN]),
        .mode(timer_control_reg[g][`DCT_MODE_HI:`DCT_MODE_LO]),
        .clr(clr_pulse[g]),
        .cc0(channel0_compare_value[g]),
        .cc1(channel1_compare_value[g]),
        .cnt(cnt),
        .ovf_ev(ovf_ev),
        .m0_ev(m0_ev),
        .m1_ev(m1_ev),
        .zero_ev(zero_ev),
        .ff_ev(ff_ev),
        .down_ev(down_ev)
      );

      dct_channel u_ch0 (
        .pclk(pclk),
        .presetn(presetn),
        .en(en0),
        .cmp_mode(chan_ctl0[g][`DCT_CMP_HI:`DCT_CMP_LO]),
        .updn(updn),
        .match(m0_ev),
        .match_down(down_ev),
        .at_zero(zero_ev),
        .at_ff(ff_ev),
        .pin_out(cmp_out[2*g]),
        .pin_oe(cmp_oe[2*g])
      );

      dct_channel u_ch1 (
        .pclk(pclk),
        .presetn(presetn),
        .en(en1),
        .cmp_mode(chan_ctl1[g][`DCT_CMP_HI:`DCT_CMP_LO]),
        .updn(updn),
        .match(m1_ev),
        .match_down(down_ev),
        .at_zero(zero_ev),
        .at_ff(ff_ev),
        .pin_out(cmp_out[2*g+1]),
        .pin_oe(cmp_oe[2*g+1])
      );

      // Flag events: overflow, channel 0, channel 1
      assign ev[3*g] = ovf_ev;
      // RULE_18 RULE_19 channel 0 flag follows zero turn in up/down
      assign ev[3*g+1] = en0 && (updn ? ovf_ev : m0_ev);
      // RULE_20 channel 1 flag on its compare in every mode
      assign ev[3*g+2] = en1 && m1_ev;
      // RULE_25 one trigger per channel compare
      assign ch_dma[2*g] = en0 && m0_ev;
      assign ch_dma[2*g+1] = en1 && m1_ev;

      assign msk[3*g] = timer_control_reg[g][`DCT_OVFM];
      assign msk[3*g+1] = chan_ctl0[g][`DCT_CH_IM];
      assign msk[3*g+2] = chan_ctl1[g][`DCT_CH_IM];
      assign pend[g] = |(timer_flag_reg[3*g +: 3] & msk[3*g +: 3]);
      // RULE_22 RULE_24 masked event or mask raised on pending flag
      assign cpu_set[g] = (|masked_ev[3*g +: 3]) || (pend[g] && !pend_d[g]);
    end
  endgenerate

  assign masked_ev = ev & msk;

  ////////////////////////////////////////////////////////////////////////
  // Flags, interrupt and DMA outputs

  // RULE_21 flags set unmasked; set wins over a same-cycle clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_flag_reg <= 6'h00;
    else if (wr && !dec_a[4] && paddr == `DCT_FLAG_OFS)
      // RULE_26 zero clears, one leaves the flag alone
      timer_flag_reg <= (timer_flag_reg & pwdata[5:0]) | ev;
    else
      timer_flag_reg <= timer_flag_reg | ev;
  end

  // CPU flag per timer, cleared by writing zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_int_flag_reg <= 2'b00;
      pend_d <= 2'b00;
    end
    else
    begin
      pend_d <= pend;
      if (wr && !dec_a[4] && paddr == `DCT_CPUIF_OFS)
        cpu_int_flag_reg <= (cpu_int_flag_reg & pwdata[1:0]) | cpu_set;
      else
        cpu_int_flag_reg <= cpu_int_flag_reg | cpu_set;
    end
  end

  // RULE_23 request needs flag and timer enable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 2'b00;
    else
      irq <= cpu_int_flag_reg & int_enable_reg;
  end

  // DMA pulses, one cycle each
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_trig <= 4'h0;
    else
      dma_trig <= ch_dma;
  end

endmodule // dct_top
`default_nettype wire

// File: sim/dct_apb_master.sv
// Bus master model standing in for the processor core.
// Assumes its task is entered just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module dct_apb_master (
  // Clock
  input wire logic pclk,
  // Bus
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  ////////////////////////////////////////
  // One transfer; ends one idle edge later so strobes never clash
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait states for as long as the slave asks; only the bench timeout ends a hang
      while (pready !== 1'b1)
      begin
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
endmodule // dct_apb_master
`default_nettype wire

// File: sim/dct_top_properties.sv
// Checker for the timer top: bus answers, pins, dma and irq.
// Assumes it is bound to dct_top running with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module dct_top_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer outputs
  input wire logic [3:0] cmp_out,
  input wire logic [3:0] cmp_oe,
  input wire logic [3:0] dma_trig,
  input wire logic [1:0] irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Access phase of a write to one address
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // Enable bit dropped in this and the last cycle
  sequence s_off(i);
    !cmp_oe[i] && !$past(cmp_oe[i]);
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (psel && penable && !pwrite && paddr == 12'h010
    |-> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
  a_read_holds: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved");
  a_oe_follow0: assert property (s_wr(12'h028) |=> cmp_oe[0] == $past(pwdata[2]))
    else $error("oe0 not from control");
  a_oe_follow3: assert property (s_wr(12'h050) |=> cmp_oe[3] == $past(pwdata[2]))
    else $error("oe3 not from control");
  a_irq_gated: assert property (s_wr(12'h008) ##0 !pwdata[0] |-> ##2 !irq[0])
    else $error("irq without enable");
  a_pin_frozen: assert property (s_off(1) |-> $stable(cmp_out[1]))
    else $error("pin moved while disabled");
  a_dma_gated: assert property (dma_trig[0] |-> $past(cmp_oe[0]))
    else $error("dma from disabled channel");
  a_reset_quiet: assert property ($rose(presetn) |-> irq == 2'h0 && dma_trig == 4'h0
    && cmp_out == 4'h0) else $error("outputs busy after reset");
endmodule // dct_top_properties
bind dct_top dct_top_properties dct_top_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_out(cmp_out),
  .cmp_oe(cmp_oe), .dma_trig(dma_trig), .irq(irq));
`default_nettype wire

// File: sim/dual_8bit_compare_timer_tb_top.sv
// Random and corner tests of the timer top over its register bus.
// Assumes the bus master model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module dual_8bit_compare_timer_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [3:0] cmp_out, cmp_oe, dma_trig;
  logic [1:0] irq;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int nd[4] = '{0, 0, 0, 0};
  int t, b, k, m, p, d0;
  dct_apb_master mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dct_top dct_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_out(cmp_out), .cmp_oe(cmp_oe), .dma_trig(dma_trig), .irq(irq));
  ////////////////////////////////////////
  // Clock; dma pulse counts; hang guard well above the run length
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++)
      nd[i] <= nd[i] + int'(dma_trig[i]);
    if (cyc == 60000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== x)
      begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", s, x, g);
      end
    end
  endtask
  // Expected bits of one timer within the shared flag register
  function automatic logic [31:0] flag_bits(input int tm, input logic [2:0] f);
    return 32'(f) << (3 * tm);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a);
    mst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wrap_up;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Main sequence on a random timer
  initial
  begin
    k = $urandom(25212);
    hold(3);
    presetn <= 1'b1;
    hold(1);
    t = $urandom % 2;
    b = 32 * (t + 1);
    rd(b + 4);
    chk("ctl_reset", 32'h08, q);
    rd(b + 8);
    chk("cctl_reset", 32'h40, q);
    rd(12'h010);
    chk("unmapped_err", 32'h1, 32'(e));
    // Every divider code, then a slower tick; loose by two for phase
    for (k = 0; k < 9; k++)
    begin
      p = (1 << (k % 8)) * (1 + k / 8);
      wr(12'h000, k / 8);
      wr(b + 4, 32'h04);
      wr(b + 4, 32'h10 | ((k % 8) << 5));
      hold(p * 100 - 3);
      wr(b + 4, 32'h00);
      rd(b);
      chk("cnt_rate", 32'h1, 32'(q >= 98 && q <= 102));
    end
    m = q;
    hold(20);
    rd(b);
    chk("cnt_frozen", m, q);
    wr(b + 4, 32'h04);
    hold(2);
    rd(b);
    chk("cnt_clear", 32'h0, q);
    // Modulo run with channel 0 set mode, mask off
    m = 8 + $urandom % 40;
    wr(12'h000, 0);
    wr(b + 12, m);
    wr(b + 8, 32'h04);
    wr(12'h004, 0);
    wr(12'h008, 1 << t);
    d0 = nd[2 * t];
    wr(b + 4, 32'h1a);
    hold(3 * m);
    wr(b + 4, 32'h0a);
    rd(b);
    chk("mod_bound", 32'h1, 32'(q <= m));
    rd(12'h004);
    chk("flags", 32'h3 << (3 * t), q);
    chk("pin_set", 32'h1, cmp_out[2 * t]);
    chk("oe", 32'h1, (cmp_oe >> (2 * t)) & 4'h3);
    chk("irq", 32'h1 << t, irq);
    chk("dma", 32'h1, 32'(nd[2 * t] > d0 && nd[2 * t + 1] == 0));
    wr(12'h004, 32'h3f);
    rd(12'h004);
    chk("flags_keep", 32'h3 << (3 * t), q);
    wr(12'h004, 0);
    wr(12'h00c, 0);
    hold(2);
    rd(12'h004);
    chk("flags_clr", 32'h0, q);
    chk("irq_clr", 32'h0, irq);
    // Clear mode, overflow and channel 0 masks off, then a late mask
    wr(b + 8, 32'h0c);
    wr(b + 4, 32'h12);
    hold(3 * m);
    wr(b + 4, 32'h02);
    chk("pin_clr", 32'h0, cmp_out[2 * t]);
    rd(12'h00c);
    chk("cpu_masked", 32'h0, q);
    wr(b + 8, 32'h4c);
    hold(2);
    rd(12'h00c);
    chk("cpu_late", 32'h1 << t, q);
    chk("irq_late", 32'h1 << t, irq);
    wr(12'h008, 0);
    hold(2);
    chk("irq_off", 32'h0, irq);
    // Down mode from a random start value
    m = 10 + $urandom % 50;
    wr(12'h004, 0);
    wr(b + 4, 32'h05);
    wr(b + 12, m);
    wr(b + 4, 32'h11);
    rd(b);
    chk("down_start", 32'h1, 32'(q <= m && q + 6 >= m));
    hold(m + 10);
    rd(b);
    chk("down_end", 32'h0, q);
    rd(12'h004);
    chk("down_ovf", 32'h1 << (3 * t), q & (32'h1 << (3 * t)));
    // Up/down with a toggling channel 1 at half the turn value
    m = 10 + $urandom % 50;
    wr(b + 4, 32'h04);
    wr(b + 12, m);
    wr(b + 16, 32'h14);
    wr(b + 20, m / 2);
    wr(12'h004, 0);
    wr(b + 4, 32'h13);
    hold(3 * m);
    wr(b + 4, 32'h03);
    rd(12'h004);
    chk("updn_flags", flag_bits(t, 3'h7), q);
    chk("pin_toggle", 32'h1, cmp_out[2 * t + 1]);
    // Free run from zero must flag overflow on reaching the top value
    wr(b + 4, 32'h04);
    wr(12'h004, 0);
    wr(b + 4, 32'h10);
    hold(300);
    rd(12'h004);
    chk("free_ovf", flag_bits(t, 3'h1), q & flag_bits(t, 3'h1));
    wrap_up();
  end
endmodule // dual_8bit_compare_timer_tb_top
`default_nettype wire
